// *** idle_timer_pkg.sv ***
// Package with modes, timing constants and carrier structs for the idle current reduction timer
package idle_timer_pkg;

  typedef enum logic [2:0] {
    SETUP_MODE,
    STEP_DIR_MODE,
    ADJUSTABLE_RATE_MODE,
    FIXED_RATE_MODE
  } opMode_e;

  localparam int CLK_HZ = 40000000;
  localparam int IDLE_TIME_S = 4;
  localparam longint IDLE_CYCLES_L = longint'(IDLE_TIME_S) * longint'(CLK_HZ);
  localparam int IDLE_CYCLES = int'(IDLE_CYCLES_L);
  localparam int IDLE_CNT_W = 28;

  // Pulse generator half period default, in cycles
  localparam int GEN_HALF_DEFAULT = 20000;
  localparam int GEN_CNT_W = 24;

  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_RESET = 28'h0000000;
  localparam logic [GEN_CNT_W-1:0] GEN_CNT_RESET = 24'h000000;

  typedef struct packed {
    logic stepPulse;
    logic runRequestN;
    logic enableN;
  } hostPins_s;

  typedef struct packed {
    logic stepOut;
    logic windingEnable;
    logic holdCurrentCut;
  } driverOut_s;

endpackage

// *** pulse_gen.sv ***
// On-board step pulse generator with programmable half period
`timescale 1ns/1ps
module pulse_gen
  import idle_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [GEN_CNT_W-1:0] halfPeriod,
  // Output
  output logic stepOut
);

  logic [GEN_CNT_W-1:0] cnt;
  logic [GEN_CNT_W-1:0] next_cnt;
  logic next_stepOut;

  always_comb begin
    next_cnt = cnt;
    next_stepOut = stepOut;
    if (!run) begin
      next_cnt = GEN_CNT_RESET;
      next_stepOut = 1'b0;
    end else if (cnt + 24'h000001 >= halfPeriod) begin
      next_cnt = GEN_CNT_RESET;
      next_stepOut = ~stepOut;
    end else begin
      next_cnt = cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= GEN_CNT_RESET;
      stepOut <= 1'b0;
    end else begin
      cnt <= next_cnt;
      stepOut <= next_stepOut;
    end
  end

endmodule

// *** idle_current_reduction_timer.sv ***
// Idle detector requesting hold current reduction, with step generator and winding enable
//
// Functional notes
// - Step/dir: cut request 4 s after last step
// - Step/dir: new step drops cut at once
// - Adjustable rate: cut 4 s after run high
// - Fixed rate: cut 4 s after run high
// - Setup modes never request current cut
// - Adjustable/fixed rate: generator steps while run request is low
// - Windings energized only while enable low
`timescale 1ns/1ps
module idle_current_reduction_timer
  import idle_timer_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Mode and generator setting
  input wire opMode_e opMode,
  input wire logic [GEN_CNT_W-1:0] genHalfPeriod,
  // Host pins
  input wire hostPins_s pins,
  // Driver outputs
  output driverOut_s drv
);

  localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT_C = IDLE_LIMIT[IDLE_CNT_W-1:0];

  function automatic logic isGenMode(input opMode_e m);
    return (m == ADJUSTABLE_RATE_MODE) || (m == FIXED_RATE_MODE);
  endfunction

  function automatic logic isNormalMode(input opMode_e m);
    return (m == STEP_DIR_MODE) || isGenMode(m);
  endfunction

  // Two-stage synchronisers for host pins
  hostPins_s syncA;
  hostPins_s syncB;
  logic stepPrev;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncA <= '{stepPulse: 1'b0, runRequestN: 1'b1, enableN: 1'b1};
      syncB <= '{stepPulse: 1'b0, runRequestN: 1'b1, enableN: 1'b1};
      stepPrev <= 1'b0;
    end else begin
      syncA <= pins;
      syncB <= syncA;
      stepPrev <= syncB.stepPulse;
    end
  end

  logic stepRise;
  logic activity;
  assign stepRise = syncB.stepPulse && !stepPrev;

  // Activity clears the idle counter
  always_comb begin
    case (opMode)
      STEP_DIR_MODE: activity = stepRise;
      ADJUSTABLE_RATE_MODE: activity = !syncB.runRequestN;
      FIXED_RATE_MODE: activity = !syncB.runRequestN;
      default: activity = 1'b1;
    endcase
  end

  logic [IDLE_CNT_W-1:0] idleCnt;
  logic [IDLE_CNT_W-1:0] next_idleCnt;
  logic next_cut;
  logic next_windingEnable;
  logic next_stepOut;
  logic genStep;
  logic genRun;

  assign genRun = isGenMode(opMode) && !syncB.runRequestN;

  always_comb begin
    next_idleCnt = idleCnt;
    if (activity || !isNormalMode(opMode)) begin
      next_idleCnt = IDLE_CNT_RESET;
    end else if (idleCnt < IDLE_LIMIT_C) begin
      next_idleCnt = idleCnt + 28'h0000001;
    end
    // Cut asserted when the idle count reaches the limit, dropped at once on activity
    next_cut = isNormalMode(opMode) && !activity && (next_idleCnt >= IDLE_LIMIT_C);
    next_windingEnable = isNormalMode(opMode) && !syncB.enableN;
    next_stepOut = isGenMode(opMode) ? genStep : syncB.stepPulse;
  end

  pulse_gen uGen (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(genRun),
    .halfPeriod(genHalfPeriod),
    .stepOut(genStep)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idleCnt <= IDLE_CNT_RESET;
      drv <= '{stepOut: 1'b0, windingEnable: 1'b0, holdCurrentCut: 1'b0};
    end else begin
      idleCnt <= next_idleCnt;
      drv.holdCurrentCut <= next_cut;
      drv.windingEnable <= next_windingEnable;
      drv.stepOut <= next_stepOut;
    end
  end

  // Checking aid: cycles that the generator output stands still while running
  logic [GEN_CNT_W:0] genQuiet;
  logic [GEN_CNT_W:0] next_genQuiet;
  logic stepOutPrev;

  always_comb begin
    next_genQuiet = genQuiet;
    if (!genRun || drv.stepOut != stepOutPrev) begin
      next_genQuiet = {1'b0, GEN_CNT_RESET};
    end else if (genQuiet != '1) begin
      next_genQuiet = genQuiet + 25'h0000001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      genQuiet <= {1'b0, GEN_CNT_RESET};
      stepOutPrev <= 1'b0;
    end else begin
      genQuiet <= next_genQuiet;
      stepOutPrev <= drv.stepOut;
    end
  end

  sequence sStepSeen;
    stepRise && opMode == STEP_DIR_MODE;
  endsequence

  sequence sLastIdleCycle;
    isNormalMode(opMode) && !activity && idleCnt == IDLE_LIMIT_C - 28'h0000001;
  endsequence

  sequence sRunStopped;
    (syncB.runRequestN && isGenMode(opMode)) [*2];
  endsequence

  AST_STEP_DROPS_CUT: assert property (@(posedge clk_sys) disable iff (!nrst)
    sStepSeen |=> !drv.holdCurrentCut)
    else $error("Cut not dropped after step");

  AST_RUN_DROPS_CUT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isGenMode(opMode) && !syncB.runRequestN) |=> !drv.holdCurrentCut)
    else $error("Cut not dropped while running");

  AST_SETUP_NO_CUT: assert property (@(posedge clk_sys) disable iff (!nrst)
    !isNormalMode($past(opMode)) |-> !drv.holdCurrentCut)
    else $error("Cut asserted in setup mode");

  AST_CUT_NEEDS_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(drv.holdCurrentCut) |-> $past(next_idleCnt) >= IDLE_LIMIT_C)
    else $error("Cut before idle time");

  AST_CNT_SATURATES: assert property (@(posedge clk_sys) disable iff (!nrst)
    idleCnt <= IDLE_LIMIT_C)
    else $error("Idle counter past limit");

  AST_CNT_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
    activity |=> idleCnt == IDLE_CNT_RESET)
    else $error("Idle counter not cleared");

  AST_CUT_RISES_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    sLastIdleCycle |=> drv.holdCurrentCut)
    else $error("Cut missing at idle limit");

  AST_ENABLE_WINDINGS: assert property (@(posedge clk_sys) disable iff (!nrst)
    drv.windingEnable |-> !$past(syncB.enableN))
    else $error("Windings on while disabled");

  AST_GEN_STOPS: assert property (@(posedge clk_sys) disable iff (!nrst)
    sRunStopped |=> !drv.stepOut)
    else $error("Generator running while run high");

  AST_GEN_KEEPS_STEPPING: assert property (@(posedge clk_sys) disable iff (!nrst)
    genQuiet <= {1'b0, genHalfPeriod} + 25'h0000003)
    else $error("Generator stalled while run low");

  AST_WINDINGS_ON: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isNormalMode(opMode) && !syncB.enableN) |=> drv.windingEnable)
    else $error("Windings off while enabled");

  AST_SETUP_NO_WINDINGS: assert property (@(posedge clk_sys) disable iff (!nrst)
    !isNormalMode(opMode) |=> !drv.windingEnable)
    else $error("Windings on in setup mode");

  AST_SETUP_CLEARS_CNT: assert property (@(posedge clk_sys) disable iff (!nrst)
    !isNormalMode(opMode) |=> idleCnt == IDLE_CNT_RESET)
    else $error("Idle counter running in setup mode");

  AST_CNT_COUNTS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isNormalMode(opMode) && !activity && idleCnt < IDLE_LIMIT_C) |=> idleCnt == $past(idleCnt) + 28'h0000001)
    else $error("Idle counter not counting");

  AST_CUT_HOLDS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (drv.holdCurrentCut && isNormalMode(opMode) && !activity) |=> drv.holdCurrentCut)
    else $error("Cut dropped without activity");

  AST_FIXED_DROPS_CUT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (opMode == FIXED_RATE_MODE && !syncB.runRequestN) |=> !drv.holdCurrentCut)
    else $error("Cut not dropped in fixed rate mode");

  AST_STEP_CUT_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    sLastIdleCycle ##0 (opMode == STEP_DIR_MODE) |=> drv.holdCurrentCut)
    else $error("Cut missing after step idle time");

  AST_ADJ_CUT_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    sLastIdleCycle ##0 (opMode == ADJUSTABLE_RATE_MODE) |=> drv.holdCurrentCut)
    else $error("Cut missing after run idle time");

  AST_STEP_RISE_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
    sStepSeen |=> idleCnt == IDLE_CNT_RESET)
    else $error("Step did not restart idle count");

endmodule

// *** host_model.sv ***
// Host motion controller model driving the step, run and enable pins
`timescale 1ns/1ps
module host_model
  import idle_timer_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Pins toward the device
  output hostPins_s pins
);
  initial pins = 3'h3;
  // One step, high and low 4 cycles each, changed on falling edges
  task automatic step();
    @(negedge clk_sys);
    pins.stepPulse = 1'h1;
    repeat (4) @(negedge clk_sys);
    pins.stepPulse = 1'h0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic setPins(input logic runN, input logic enN);
    pins.runRequestN = runN;
    pins.enableN = enN;
  endtask
endmodule

// *** tb.sv ***
// Self-checking testbench for the idle current reduction timer
`timescale 1ns/1ps
module tb;
  import idle_timer_pkg::*;
  localparam int LIM = 12;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  opMode_e opMode = SETUP_MODE;
  logic [GEN_CNT_W-1:0] genHalfPeriod = 24'h000002;
  hostPins_s pins;
  driverOut_s drv;
  int n_fail = 0;
  int compares = 0;
  always #12.5 clk_sys = ~clk_sys;
  host_model i_host (.clk_sys(clk_sys), .pins(pins));
  idle_current_reduction_timer #(.IDLE_LIMIT(LIM)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .opMode(opMode),
    .genHalfPeriod(genHalfPeriod), .pins(pins), .drv(drv));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Bounded wait for the cut request to reach level v
  task automatic waitCut(input logic v, output int n);
    n = 0;
    while (drv.holdCurrentCut !== v && n < 4 * LIM) begin
      @(negedge clk_sys);
      n++;
    end
    if (drv.holdCurrentCut !== v) begin
      n_fail++;
      $display("ERROR t=%0t timeout got=%0h exp=%0h", $time, drv.holdCurrentCut, v);
      summarize();
    end
  endtask
  task automatic t_step();
    int n;
    opMode = STEP_DIR_MODE;
    i_host.step();
    waitCut(1'h1, n);
    check(32'(n >= LIM - 8 && n <= LIM - 2), 1);
    repeat (2 * LIM) @(negedge clk_sys);
    check(drv.holdCurrentCut, 1);
    i_host.step();
    check(drv.holdCurrentCut, 0);
    $display("t_step done");
  endtask
  task automatic t_gen(input opMode_e m);
    int n;
    int t = 0;
    logic prev;
    opMode = m;
    i_host.setPins(1'h0, 1'h0);
    repeat (5) @(negedge clk_sys);
    check(drv.holdCurrentCut, 0);
    check(drv.windingEnable, 1);
    repeat (20) begin
      @(negedge clk_sys);
      t += int'(drv.stepOut);
    end
    check(32'(t >= 8 && t <= 12), 1);
    i_host.setPins(1'h1, 1'h0);
    waitCut(1'h1, n);
    check(32'(n >= LIM - 1 && n <= LIM + 4), 1);
    prev = drv.stepOut;
    t = 0;
    repeat (10) begin
      @(negedge clk_sys);
      t += int'(drv.stepOut !== prev);
      prev = drv.stepOut;
    end
    check(t, 0);
    i_host.setPins(1'h0, 1'h0);
    repeat (4) @(negedge clk_sys);
    check(drv.holdCurrentCut, 0);
    i_host.setPins(1'h1, 1'h0);
    repeat (4) @(negedge clk_sys);
    $display("t_gen done");
  endtask
  task automatic t_setup();
    int t = 0;
    opMode = SETUP_MODE;
    repeat (3 * LIM) begin
      @(negedge clk_sys);
      t += int'(drv.holdCurrentCut !== 1'h0);
    end
    check(t, 0);
    opMode = STEP_DIR_MODE;
    i_host.setPins(1'h1, 1'h1);
    repeat (5) @(negedge clk_sys);
    check(drv.windingEnable, 0);
    $display("t_setup done");
  endtask
  // Reset in mid-run clears the outputs; the idle count restarts from release
  task automatic t_reset();
    int n;
    opMode = STEP_DIR_MODE;
    i_host.setPins(1'h1, 1'h0);
    waitCut(1'h1, n);
    check(drv.holdCurrentCut, 1);
    nrst = 1'h0;
    repeat (2) @(negedge clk_sys);
    check(32'(drv), 0);
    nrst = 1'h1;
    waitCut(1'h1, n);
    check(n, LIM);
    $display("t_reset done");
  endtask
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    nrst = 1'h1;
    t_step();
    t_gen(ADJUSTABLE_RATE_MODE);
    t_gen(FIXED_RATE_MODE);
    t_setup();
    t_reset();
    summarize();
  end
endmodule
